// ---- design/nfbp_host.sv ----
`timescale 1ns/1ns
`include "nfbp_defs.svh"
//---------------------------------------------------------------
//---------------------------------------------------------------
module nfbp_host
  import nfbp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // request
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic req_half_in,
  input wire logic [23:0] req_addr_in,
  input wire logic [9:0] req_len_in,
  output logic req_ready_out,
  output logic done_out,
  // write data stream
  input wire logic [7:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // read data stream
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  // flash pins
  output logic [7:0] io_bus_out,
  output logic io_bus_oe_n_out,
  input wire logic [7:0] io_bus_in,
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic chip_sel_n_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic write_prot_n_out,
  input wire logic ready_busy_in
);
  nfbp_state_e state_reg;
  logic [1:0] op_reg;
  logic half_reg;
  logic [23:0] addr_reg;
  logic [9:0] len_reg;
  logic [1:0] acyc_reg;
  logic [3:0] tick_reg;
  logic [3:0] bwait_reg;
  logic phase_reg;
  logic [7:0] cmd_reg;
  logic rb_meta_reg;
  logic rb_reg;
  logic [7:0] io_meta_reg;
  logic [7:0] io_sync_reg;
  logic tick_done;
  logic step;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;

  // address byte for cycle n; bit 8 is skipped, the read command carries the half from req_half_in
  function automatic logic [7:0] addr_byte(input logic [23:0] a, input logic [1:0] n);
    unique case (n)
      2'd0: addr_byte = a[7:0];
      2'd1: addr_byte = a[16:9];
      default: addr_byte = {1'b0, a[23:17]};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rb_meta_reg <= 1'b1;
      rb_reg <= 1'b1;
      io_meta_reg <= '0;
      io_sync_reg <= '0;
    end else if (ce_in) begin
      rb_meta_reg <= ready_busy_in;
      rb_reg <= rb_meta_reg;
      io_meta_reg <= io_bus_in;
      io_sync_reg <= io_meta_reg;
    end
  end

  // phase timer: each strobe half lasts a fixed count, except read phase 0, held while the fifo is full
  assign tick_done = (tick_reg == 4'(`NFBP_PHASE_CYC - 1));
  assign step = tick_done && phase_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_reg <= '0;
      phase_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg == NFBP_IDLE || state_reg == NFBP_WAIT_READY || state_reg == NFBP_WAIT_BUSY) begin
        tick_reg <= '0;
        phase_reg <= 1'b0;
      end else if (state_reg == NFBP_RDATA && !phase_reg && !fifo_in_ready) begin
        tick_reg <= '0; // back-pressure: hold read strobe high until room
      end else if (tick_done) begin
        tick_reg <= '0;
        phase_reg <= ~phase_reg;
      end else begin
        tick_reg <= tick_reg + 4'd1;
      end
    end
  end

  // busy wait limit: commands such as reset may never pull busy low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bwait_reg <= '0;
    end else if (ce_in) begin
      if (state_reg != NFBP_WAIT_BUSY) begin
        bwait_reg <= '0;
      end else if (bwait_reg != 4'(`NFBP_BUSY_LIMIT_CYC)) begin
        bwait_reg <= bwait_reg + 4'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= NFBP_IDLE;
      op_reg <= `NFBP_OP_READ;
      half_reg <= 1'b0;
      addr_reg <= '0;
      len_reg <= '0;
      acyc_reg <= '0;
      cmd_reg <= '0;
    end else if (ce_in) begin
      unique case (state_reg)
        NFBP_IDLE: begin
          if (req_valid_in && req_ready_out) begin
            op_reg <= req_op_in;
            half_reg <= req_half_in;
            addr_reg <= req_addr_in;
            len_reg <= req_len_in;
            acyc_reg <= (req_op_in == `NFBP_OP_ERASE) ? 2'd1 : 2'd0;
            unique case (req_op_in)
              `NFBP_OP_READ: cmd_reg <= req_half_in ? `NFBP_CMD_READ_B : `NFBP_CMD_READ_A;
              `NFBP_OP_PROG: cmd_reg <= `NFBP_CMD_PROG_SETUP;
              `NFBP_OP_ERASE: cmd_reg <= `NFBP_CMD_ERASE_SETUP;
              default: cmd_reg <= `NFBP_CMD_RESET;
            endcase
            state_reg <= NFBP_CMD;
          end else if (req_valid_in && !rb_reg && req_op_in == `NFBP_OP_RESET) begin
            op_reg <= req_op_in; // reset is accepted while busy
            cmd_reg <= `NFBP_CMD_RESET;
            state_reg <= NFBP_CMD;
          end
        end
        NFBP_CMD: if (step) begin
          state_reg <= (op_reg == `NFBP_OP_RESET) ? NFBP_WAIT_BUSY : NFBP_ADDR;
        end
        NFBP_ADDR: if (step) begin
          acyc_reg <= acyc_reg + 2'd1;
          if (acyc_reg == 2'd2) begin // exactly the cycles needed
            unique case (op_reg)
              `NFBP_OP_PROG: state_reg <= NFBP_WDATA;
              `NFBP_OP_ERASE: state_reg <= NFBP_CONFIRM;
              default: state_reg <= NFBP_WAIT_BUSY;
            endcase
            cmd_reg <= (op_reg == `NFBP_OP_PROG) ? `NFBP_CMD_PROG_CONFIRM : `NFBP_CMD_ERASE_CONFIRM;
          end
        end
        NFBP_WDATA: if (step) begin
          len_reg <= len_reg - 10'd1;
          if (len_reg == 10'd1) begin
            state_reg <= NFBP_CONFIRM;
          end
        end
        NFBP_CONFIRM: if (step) begin
          state_reg <= NFBP_WAIT_BUSY;
        end
        NFBP_WAIT_BUSY: begin
          if (!rb_reg || bwait_reg == 4'(`NFBP_BUSY_LIMIT_CYC)) begin
            state_reg <= NFBP_WAIT_READY;
          end
        end
        NFBP_WAIT_READY: begin
          if (rb_reg) begin
            state_reg <= (op_reg == `NFBP_OP_READ && len_reg != '0) ? NFBP_RDATA : NFBP_IDLE;
          end
        end
        NFBP_RDATA: if (step) begin // one byte per strobe fall
          len_reg <= len_reg - 10'd1;
          if (len_reg == 10'd1) begin
            state_reg <= NFBP_IDLE;
          end
        end
        default: state_reg <= NFBP_IDLE;
      endcase
    end
  end

  // the fifo takes the byte at the end of the high phase, once it has crossed both sync flops
  assign fifo_in_valid = (state_reg == NFBP_RDATA) && step;
  assign fifo_out_ready = !rd_valid_out || rd_ready_in;

  nfbp_fifo #(.WIDTH(8), .DEPTH(`NFBP_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_data_in(io_sync_reg),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .out_data_out(fifo_out_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready)
  );

  // ---------------------------------------------------------------
  // registered pin and user outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      io_bus_out <= '0;
      io_bus_oe_n_out <= 1'b1;
      cmd_latch_out <= 1'b0;
      addr_latch_out <= 1'b0;
      chip_sel_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      write_prot_n_out <= 1'b0; // protected until a program or erase request leaves idle
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      wr_ready_out <= 1'b0;
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      cmd_latch_out <= (state_reg == NFBP_CMD || state_reg == NFBP_CONFIRM);
      addr_latch_out <= (state_reg == NFBP_ADDR);
      chip_sel_n_out <= (state_reg == NFBP_IDLE);
      // write strobe low in phase 0, rises at phase 1 to latch
      write_strobe_n_out <= !((state_reg == NFBP_CMD || state_reg == NFBP_ADDR || state_reg == NFBP_WDATA
                            || state_reg == NFBP_CONFIRM) && !phase_reg);
      read_strobe_n_out <= !(state_reg == NFBP_RDATA && !phase_reg && fifo_in_ready);
      io_bus_oe_n_out <= (state_reg == NFBP_IDLE || state_reg == NFBP_RDATA
                          || state_reg == NFBP_WAIT_BUSY || state_reg == NFBP_WAIT_READY);
      unique case (state_reg)
        NFBP_ADDR: io_bus_out <= addr_byte(addr_reg, acyc_reg);
        NFBP_WDATA: if (!phase_reg) begin
          io_bus_out <= wr_data_in; // held through the strobe rise
        end
        default: io_bus_out <= cmd_reg;
      endcase
      write_prot_n_out <= (state_reg != NFBP_IDLE) && (op_reg == `NFBP_OP_PROG || op_reg == `NFBP_OP_ERASE);
      req_ready_out <= (state_reg == NFBP_IDLE) && rb_reg && !(req_valid_in && req_ready_out);
      done_out <= (state_reg == NFBP_WAIT_READY && rb_reg && !(op_reg == `NFBP_OP_READ && len_reg != '0))
                  || (state_reg == NFBP_RDATA && step && len_reg == 10'd1);
      wr_ready_out <= (state_reg == NFBP_WDATA) && tick_done && !phase_reg && !wr_ready_out;
      if (fifo_out_ready) begin
        rd_data_out <= fifo_out_data;
        rd_valid_out <= fifo_out_valid;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  cmd_no_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(cmd_latch_out && addr_latch_out)) else $error("both latch enables high");
  addr_b7_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NFBP_ADDR && acyc_reg == 2'd2 && ce_in) |=> !io_bus_out[7]) else $error("third address bit 7 high");
  erase_two_cyc_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NFBP_IDLE && $past(state_reg) != NFBP_IDLE && op_reg == `NFBP_OP_ERASE) |-> acyc_reg == 2'd3)
    else $error("erase address count wrong");
  busy_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(state_reg == NFBP_CMD) && !rb_reg) |-> cmd_reg == `NFBP_CMD_RESET) else $error("command while busy");
  rd_strobe_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !read_strobe_n_out |-> io_bus_oe_n_out) else $error("read while driving bus");
  wp_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    write_prot_n_out |-> (op_reg == `NFBP_OP_PROG || op_reg == `NFBP_OP_ERASE))
    else $error("write protect released outside program or erase");
  // read strobe pulse: two cycles low, then high again
  sequence rd_low_s;
    ##1 !read_strobe_n_out;
  endsequence
  sequence rd_high_s;
    ##1 read_strobe_n_out;
  endsequence
  rd_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in || !ce_in)
    $fell(read_strobe_n_out) |-> rd_low_s ##0 rd_high_s) else $error("read strobe pulse width wrong");
endmodule

// ---- design/nfbp_defs.svh ----
`ifndef NFBP_DEFS_SVH
`define NFBP_DEFS_SVH
// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define NFBP_CMD_READ_A 8'h00
`define NFBP_CMD_READ_B 8'h01
`define NFBP_CMD_PROG_SETUP 8'h80
`define NFBP_CMD_PROG_CONFIRM 8'h10
`define NFBP_CMD_ERASE_SETUP 8'h60
`define NFBP_CMD_ERASE_CONFIRM 8'hD0
`define NFBP_CMD_STATUS 8'h70
`define NFBP_CMD_RESET 8'hFF
// ---------------------------------------------------------------
// request opcodes on the user port
// ---------------------------------------------------------------
`define NFBP_OP_READ 2'h0
`define NFBP_OP_PROG 2'h1
`define NFBP_OP_ERASE 2'h2
`define NFBP_OP_RESET 2'h3
// ---------------------------------------------------------------
// timing: each strobe phase is held this long (ns), 40 ns clock
// ---------------------------------------------------------------
`define NFBP_CLK_NS 40
`define NFBP_PHASE_NS 80
`define NFBP_PHASE_CYC ((`NFBP_PHASE_NS + `NFBP_CLK_NS - 1) / `NFBP_CLK_NS)
// busy arrives within this time after the last write strobe
`define NFBP_BUSY_WAIT_NS 200
`define NFBP_BUSY_WAIT_CYC ((`NFBP_BUSY_WAIT_NS + `NFBP_CLK_NS - 1) / `NFBP_CLK_NS)
// give up waiting for busy after this many cycles, covering the two sync flops
`define NFBP_BUSY_LIMIT_CYC (`NFBP_BUSY_WAIT_CYC + 3)
`define NFBP_PAGE_BYTES 10'h210
`define NFBP_HALF_BYTES 10'h200
`define NFBP_HALF_BIT 8
`define NFBP_FIFO_DEPTH 8
`endif

// ---- design/nfbp_pkg.sv ----
package nfbp_pkg;
  typedef enum logic [3:0] {
    NFBP_IDLE = 4'b0000,
    NFBP_CMD = 4'b0001,
    NFBP_ADDR = 4'b0010,
    NFBP_WDATA = 4'b0011,
    NFBP_CONFIRM = 4'b0100,
    NFBP_WAIT_BUSY = 4'b0101,
    NFBP_WAIT_READY = 4'b0110,
    NFBP_RDATA = 4'b0111
  } nfbp_state_e;
endpackage

// ---- design/nfbp_fifo.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// small synchronous fifo, valid/ready on both sides
// ---------------------------------------------------------------
module nfbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  // full/empty straight from the count
  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_reg];
  assign push = in_valid_in && in_ready_out && ce_in;
  assign pop = out_valid_out && out_ready_in && ce_in;
  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end
  // pointers and occupancy
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// ---- verif/nfbp_flash_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// behavioural flash device beyond the host port
// ---------------------------------------------------------------
module nfbp_flash_model #(
  parameter bit SPARE_SEL = 1'b0,
  parameter int READ_NS = 10000,
  parameter int PROG_NS = 8000,
  parameter int ERASE_NS = 20000
) (
  // strobes and latches
  input wire logic cmd_latch_in,
  input wire logic addr_latch_in,
  input wire logic chip_sel_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_prot_n_in,
  // bus and status
  input wire logic [7:0] io_bus_in,
  output logic [7:0] io_bus_out,
  output logic ready_busy_out
);
  byte unsigned mem [int];
  byte unsigned pbuf [int];
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] ab [0:2];
  logic busy = 1'b0;
  logic half = 1'b0;
  int n_addr = 0, n_data = 0, ptr = 0, row = 0, bad_bit7 = 0, busy_viol = 0;
  // open drain with pull-up, never floats on deselect
  assign ready_busy_out = !busy;
  initial io_bus_out = 8'h5a;
  // lag before busy so the host sees a clean fall; chip select cannot cut it short
  task automatic go_busy(input int ns);
    fork
      begin
        #100 busy = 1'b1;
        #(ns) busy = 1'b0;
      end
    join_none
  endtask
  // command decode
  task automatic do_cmd(input logic [7:0] c);
    int b;
    b = row / 32 * 32;
    if (c == 8'h00 || c == 8'h01) begin
      cmd_reg = 8'h00;
      half = c[0];
      n_addr = 0;
    end else if (c == 8'h80 || c == 8'h60) begin
      cmd_reg = c;
      n_addr = 0;
      n_data = 0;
      pbuf.delete();
    end else if (c == 8'h10 && cmd_reg == 8'h80 && write_prot_n_in) begin
      foreach (pbuf[k]) mem[k] = pbuf[k];
      go_busy(PROG_NS);
    end else if (c == 8'hd0 && cmd_reg == 8'h60 && write_prot_n_in) begin
      for (int p = 0; p < 32 * 528; p++) mem.delete(b * 528 + p);
      go_busy(ERASE_NS);
    end else if (c != 8'h70) begin
      cmd_reg = c;
    end
  endtask
  // address cycles; surplus ones are dropped
  task automatic do_addr(input logic [7:0] a);
    int need;
    need = (cmd_reg == 8'h60) ? 2 : 3;
    if (n_addr < need) begin
      ab[n_addr + 3 - need] = a;
      n_addr++;
      if (n_addr == need) begin
        if (ab[2][7]) bad_bit7++;
        row = {ab[2][6:0], ab[1]};
        ptr = {half, ab[0]};
        half = 1'b0;
        if (cmd_reg == 8'h00) go_busy(READ_NS);
      end
    end
  endtask
  // write strobe rise latches command, address or data
  always @(posedge write_strobe_n_in) begin
    if (!chip_sel_n_in) begin
      if (cmd_latch_in && busy && io_bus_in != 8'h70 && io_bus_in != 8'hff) busy_viol++;
      if (cmd_latch_in) do_cmd(io_bus_in);
      else if (addr_latch_in) do_addr(io_bus_in);
      else if (cmd_reg == 8'h80) begin
        pbuf[row * 528 + ptr] = io_bus_in;
        ptr++;
        n_data++;
      end
    end
  end
  // read strobe fall hands out the next byte after an access lag
  always @(negedge read_strobe_n_in) begin
    if (!chip_sel_n_in && !busy) begin
      io_bus_out <= #20 mem.exists(row * 528 + ptr) ? mem[row * 528 + ptr] : 8'hff;
      ptr++;
      if (ptr == (SPARE_SEL ? 512 : 528)) begin
        ptr = 0;
        row++;
      end
    end
  end
  // released bus turns to junk so a stale byte cannot pass
  always @(posedge read_strobe_n_in or posedge chip_sel_n_in) begin
    io_bus_out <= #60 ~io_bus_out;
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// host port bench against the flash model
// ---------------------------------------------------------------
module testbench;
  logic clk = 0, rst = 1, req_valid = 0, half = 0, stall = 0, rd_ready = 0;
  logic [1:0] op = 0;
  logic [23:0] addr = 0;
  logic [9:0] len = 0;
  logic [7:0] wr_data = 0;
  logic req_ready, done, wr_ready, rd_valid, oe_n, cle, ale, ce_n, we_n, re_n, wp_n, rb;
  logic [7:0] rd_data, io_o, io_dev;
  wire [7:0] io = oe_n ? io_dev : io_o;
  int miscompares = 0, n_checks = 0;
  byte unsigned ref_mem [int];
  logic [7:0] exp_q [$], wr_q [$];
  always #20 clk = ~clk;
  nfbp_host nfbp_host_inst (
    .clk_in(clk), .rst_in(rst), .ce_in(1'b1), .req_valid_in(req_valid), .req_op_in(op),
    .req_half_in(half), .req_addr_in(addr), .req_len_in(len), .req_ready_out(req_ready),
    .done_out(done), .wr_data_in(wr_data), .wr_valid_in(1'b1), .wr_ready_out(wr_ready),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
    .io_bus_out(io_o), .io_bus_oe_n_out(oe_n), .io_bus_in(io), .cmd_latch_out(cle),
    .addr_latch_out(ale), .chip_sel_n_out(ce_n), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .write_prot_n_out(wp_n), .ready_busy_in(rb));
  nfbp_flash_model nfbp_flash_model_inst (
    .cmd_latch_in(cle), .addr_latch_in(ale), .chip_sel_n_in(ce_n), .write_strobe_n_in(we_n),
    .read_strobe_n_in(re_n), .write_prot_n_in(wp_n), .io_bus_in(io), .io_bus_out(io_dev),
    .ready_busy_out(rb));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // expected read bytes; unwritten cells read erased
  task automatic load_exp(int idx, int n);
    for (int k = 0; k < n; k++) exp_q.push_back(ref_mem.exists(idx + k) ? ref_mem[idx + k] : 8'hff);
  endtask
  // one request, held until taken, then bounded wait for done
  task automatic run_op(logic [1:0] o, logic h, logic [23:0] a, logic [9:0] n);
    int t;
    @(negedge clk);
    op = o;
    half = h;
    addr = a;
    len = n;
    req_valid = 1'b1;
    t = 0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++t < 1000);
    check("taken", t < 1000, 1);
    @(negedge clk);
    req_valid = 1'b0;
    t = 0;
    do @(posedge clk); while (done !== 1'b1 && ++t < 20000);
    check("done", t < 20000, 1);
    t = 0;
    while (exp_q.size() != 0 && t++ < 200) @(posedge clk);
    check("read queue", exp_q.size(), 0);
    $display("test op %0d half %0d finished", o, h);
  endtask
  // read stream consumer, transfer on valid and ready at the edge
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready) check("rd byte", rd_data, exp_q.pop_front());
  end
  // write bytes advance on each take; read ready toggles randomly unless stalled
  always @(negedge clk) begin
    if (wr_ready === 1'b1 && wr_q.size() != 0) void'(wr_q.pop_front());
    wr_data = wr_q.size() != 0 ? wr_q[0] : 8'h00;
    rd_ready = !stall && $urandom_range(3) != 0;
  end
  // watchdog, far beyond the sum of all busy times
  initial begin
    #3000000;
    miscompares++;
    complete_run();
  end
  initial begin
    int r, b;
    logic [7:0] d;
    void'($urandom(65109));
    r = $urandom_range(32767);
    b = r / 32 * 32;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // program crossing into the second half
    for (int k = 0; k < 12; k++) begin
      d = $urandom;
      wr_q.push_back(d);
      ref_mem[r * 528 + 250 + k] = d;
    end
    run_op(2'h1, 1'b0, {r[14:0], 1'b0, 8'hfa}, 10'h00c);
    check("prog bytes", nfbp_flash_model_inst.n_data, 12);
    check("bytes left", wr_q.size(), 0);
    @(negedge clk);
    check("wp idle", wp_n, 0);
    load_exp(r * 528 + 250, 12);
    run_op(2'h0, 1'b0, {r[14:0], 1'b0, 8'hfa}, 10'h00c);
    load_exp(r * 528 + 256, 6);
    run_op(2'h0, 1'b1, {r[14:0], 1'b0, 8'h00}, 10'h006);
    // reader stalls so the fifo fills, then drains
    stall = 1'b1;
    load_exp(r * 528 + 240, 24);
    fork
      run_op(2'h0, 1'b0, {r[14:0], 1'b0, 8'hf0}, 10'h018);
      begin
        repeat (600) @(negedge clk);
        stall = 1'b0;
      end
    join
    for (int k = 0; k < 32 * 528; k++) ref_mem.delete(b * 528 + k);
    run_op(2'h2, 1'b0, {r[14:0], 1'b0, 8'h00}, 10'h000);
    check("erase cycles", nfbp_flash_model_inst.n_addr, 2);
    load_exp(r * 528 + 250, 12);
    run_op(2'h0, 1'b0, {r[14:0], 1'b0, 8'hfa}, 10'h00c);
    run_op(2'h3, 1'b0, 24'h00_0000, 10'h000);
    check("reset cmd", nfbp_flash_model_inst.cmd_reg, 8'hff);
    check("addr bit7", nfbp_flash_model_inst.bad_bit7, 0);
    check("busy cmds", nfbp_flash_model_inst.busy_viol, 0);
    complete_run();
  end
endmodule
